/* File: logic/tcm_map.svh */
// register map, field positions and codes for the compare-output timer
// What this block does
// R1 - reset clears compare output state bits
// R2 - nonzero action routes state onto pin
// R3 - direction bit alone sets pin direction
// R4 - override ignores the waveform mode
// R5 - state settable while pin is input
// R6 - action zero leaves state alone
// R7 - new action applies at next match
// R8 - force strobe applies action at once in non-pwm modes
// R9 - only mode select sets counting sequence
// R10 - action sets, clears or toggles state
// R11 - normal mode counts up, wraps freely
// R12 - overflow flag set when counter wraps
// R13 - hardware only sets overflow flag
// R14 - counter writable at any time
// R15 - software avoids waveforms in normal mode
// R16 - clear-on-match clears counter after match
// R17 - compare flag a set at top
// R18 - unbuffered compare value may miss once
// R19 - action one toggles state a
// R20 - toggle rate follows prescale and top
// R21 - prescale ratios 1, 8, 64, 256, 1024
// R22 - overflow still set on max rollover
// R23 - compare flag set one tick later
// R24 - counter write blocks next tick's match
// R25 - force touches neither flag nor counter
// R26 - writing one clears a flag
// R27 - logic advances only on tick enable
// R28 - counter write beats clear or count
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH

`define TCM_OFF_CTRL   8'h00
`define TCM_OFF_FORCE  8'h04
`define TCM_OFF_COUNT  8'h08
`define TCM_OFF_CMPA   8'h0C
`define TCM_OFF_CMPB   8'h10
`define TCM_OFF_FLAGS  8'h14
`define TCM_OFF_PORT   8'h18

`define TCM_CTRL_WGM   2:0
`define TCM_CTRL_CS    5:3
`define TCM_CTRL_ACTA  7:6
`define TCM_CTRL_ACTB  9:8
`define TCM_PORT_OUT   1:0
`define TCM_PORT_DIR   3:2
`define TCM_PORT_OC    5:4
`define TCM_FLG_OVF    0
`define TCM_FLG_CMPA   1
`define TCM_FLG_CMPB   2
`define TCM_WGM_PWM    0

`define TCM_WGM_NORMAL 3'h0
`define TCM_WGM_CTC    3'h2
`define TCM_ACT_NONE   2'h0
`define TCM_ACT_TOGGLE 2'h1
`define TCM_ACT_CLEAR  2'h2
`define TCM_ACT_SET    2'h3

`define TCM_CS_DIV1    3'h1
`define TCM_CS_DIV8    3'h2
`define TCM_CS_DIV64   3'h3
`define TCM_CS_DIV256  3'h4
`define TCM_CS_DIV1024 3'h5
`define TCM_MASK8      10'h007
`define TCM_MASK64     10'h03F
`define TCM_MASK256    10'h0FF
`define TCM_MASK1024   10'h3FF

`define TCM_MAX        8'hFF
`define TCM_BOTTOM     8'h00
`define TCM_PRESC_STEP 10'h001

`endif

/* File: logic/tcm_pkg.sv */
// types shared by the compare-output timer
package tcm_pkg;

	typedef enum logic [1:0] {
		TCM_ST_IDLE = 2'b01,
		TCM_ST_ACC  = 2'b10
	} tcm_apb_state_type;

	typedef struct packed {
		logic [1:0] level;
		logic [1:0] oe;
	} tcm_pins_type;

	typedef struct packed {
		tcm_apb_state_type apb_st;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
		logic [2:0]        wgm;
		logic [2:0]        cs;
		logic [1:0][1:0]   act;
		logic [7:0]        count;
		logic [1:0][7:0]   cmp;
		logic              block;
		logic              ovf;
		logic [1:0]        cflag;
		logic [1:0]        oc;
		logic [1:0]        port_out;
		logic [1:0]        dir;
		logic [9:0]        presc;
		logic              tick;
		tcm_pins_type      pins;
	} tcm_state_type;

endpackage

/* File: logic/tcm_timer.sv */
// 8-bit timer with normal and clear-on-match modes and two compare outputs
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "tcm_map.svh"

module tcm_timer
	import tcm_pkg::*;
(
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	// apb slave
	input  wire logic         i_psel,
	input  wire logic         i_penable,
	input  wire logic         i_pwrite,
	input  wire logic [7:0]   i_paddr,
	input  wire logic [31:0]  i_pwdata,
	output var  logic [31:0]  o_prdata,
	output var  logic         o_pready,
	output var  logic         o_pslverr,
	// interrupt service acknowledges
	input  wire logic         i_svc_ovf,
	input  wire logic         i_svc_cmp_a,
	input  wire logic         i_svc_cmp_b,
	// compare pins
	output var  tcm_pins_type o_pins,
	// flag levels
	output var  logic         o_ovf_flag,
	output var  logic [1:0]   o_cmp_flag
);

	tcm_state_type s_r;
	tcm_state_type s_nxt;

	logic          wr_en;
	logic          wr_ctrl;
	logic          wr_force;
	logic          wr_count;
	logic          wr_cmpa;
	logic          wr_cmpb;
	logic          wr_flags;
	logic          wr_port;
	logic          addr_hit;
	logic [31:0]   rd_data;
	logic          pwm_mode;
	logic          ctc_mode;
	logic [1:0]    hit;
	logic [1:0]    force_hit;
	logic [1:0]    oc_nxt;
	logic [1:0]    svc_cmp;

	function automatic logic apply_action(input logic [1:0] act, input logic cur);
		logic res;
		res = cur;
		case (act)
			`TCM_ACT_TOGGLE: res = ~cur;
			`TCM_ACT_CLEAR:  res = 1'b0;
			`TCM_ACT_SET:    res = 1'b1;
			default:         res = cur;
		endcase
		return res;
	endfunction

	// write strobes commit at the access edge while pready is high
	assign wr_en    = (s_r.apb_st == TCM_ST_ACC) && i_psel && i_penable && i_pwrite;
	assign wr_ctrl  = wr_en && (i_paddr == `TCM_OFF_CTRL);
	assign wr_force = wr_en && (i_paddr == `TCM_OFF_FORCE);
	assign wr_count = wr_en && (i_paddr == `TCM_OFF_COUNT);
	assign wr_cmpa  = wr_en && (i_paddr == `TCM_OFF_CMPA);
	assign wr_cmpb  = wr_en && (i_paddr == `TCM_OFF_CMPB);
	assign wr_flags = wr_en && (i_paddr == `TCM_OFF_FLAGS);
	assign wr_port  = wr_en && (i_paddr == `TCM_OFF_PORT);

	assign pwm_mode = s_r.wgm[`TCM_WGM_PWM];
	assign ctc_mode = (s_r.wgm == `TCM_WGM_CTC);
	assign svc_cmp  = {i_svc_cmp_b, i_svc_cmp_a};

	always_comb
	begin
		addr_hit = 1'b1;
		rd_data  = 32'h0000_0000;
		case (i_paddr)
			`TCM_OFF_CTRL:
			begin
				rd_data[`TCM_CTRL_WGM]  = s_r.wgm;
				rd_data[`TCM_CTRL_CS]   = s_r.cs;
				rd_data[`TCM_CTRL_ACTA] = s_r.act[0];
				rd_data[`TCM_CTRL_ACTB] = s_r.act[1];
			end
			`TCM_OFF_FORCE: rd_data = 32'h0000_0000;
			`TCM_OFF_COUNT: rd_data[7:0] = s_r.count;
			`TCM_OFF_CMPA:  rd_data[7:0] = s_r.cmp[0];
			`TCM_OFF_CMPB:  rd_data[7:0] = s_r.cmp[1];
			`TCM_OFF_FLAGS:
			begin
				rd_data[`TCM_FLG_OVF]  = s_r.ovf;
				rd_data[`TCM_FLG_CMPA] = s_r.cflag[0];
				rd_data[`TCM_FLG_CMPB] = s_r.cflag[1];
			end
			`TCM_OFF_PORT:
			begin
				rd_data[`TCM_PORT_OUT] = s_r.port_out;
				rd_data[`TCM_PORT_DIR] = s_r.dir;
				rd_data[`TCM_PORT_OC]  = s_r.oc;
			end
			default: addr_hit = 1'b0;
		endcase
	end

	// per-channel compare match and output state
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			// a match is seen on the tick after the counter equals the compare value
			assign hit[ch] = s_r.tick && (s_r.count == s_r.cmp[ch]) && !s_r.block; // R23 R24 R27
			// force only in non-pwm modes, independent of pin direction
			assign force_hit[ch] = wr_force && i_pwdata[ch] && !pwm_mode; // R8 R5
			// action register value in force now is used, so a new action acts at next match
			assign oc_nxt[ch] = (hit[ch] || force_hit[ch]) ?
				apply_action(s_r.act[ch], s_r.oc[ch]) : s_r.oc[ch]; // R6 R7 R10 R19
		end
	endgenerate

	always_comb
	begin
		s_nxt         = s_r;
		s_nxt.pready  = 1'b0;
		s_nxt.pslverr = 1'b0;

		// apb: one setup cycle, then a single access cycle with pready high
		case (s_r.apb_st)
			TCM_ST_IDLE:
			begin
				if (i_psel && !i_penable)
				begin
					s_nxt.apb_st  = TCM_ST_ACC;
					s_nxt.pready  = 1'b1;
					s_nxt.pslverr = !addr_hit;
					s_nxt.prdata  = i_pwrite ? 32'h0000_0000 : rd_data;
				end
			end
			TCM_ST_ACC: s_nxt.apb_st = TCM_ST_IDLE;
			default:    s_nxt.apb_st = TCM_ST_IDLE;
		endcase

		if (wr_ctrl)
		begin
			// mode select alone steers counting; actions alone steer outputs
			s_nxt.wgm    = i_pwdata[`TCM_CTRL_WGM]; // R9
			s_nxt.cs     = i_pwdata[`TCM_CTRL_CS];
			s_nxt.act[0] = i_pwdata[`TCM_CTRL_ACTA];
			s_nxt.act[1] = i_pwdata[`TCM_CTRL_ACTB];
		end
		if (wr_cmpa)
			s_nxt.cmp[0] = i_pwdata[7:0]; // R18
		if (wr_cmpb)
			s_nxt.cmp[1] = i_pwdata[7:0];
		if (wr_port)
		begin
			s_nxt.port_out = i_pwdata[`TCM_PORT_OUT];
			s_nxt.dir      = i_pwdata[`TCM_PORT_DIR];
		end

		// prescaler produces a one-cycle tick enable
		s_nxt.presc = s_r.presc + `TCM_PRESC_STEP;
		case (s_r.cs)
			`TCM_CS_DIV1:    s_nxt.tick = 1'b1; // R21
			`TCM_CS_DIV8:    s_nxt.tick = ((s_r.presc & `TCM_MASK8) == `TCM_MASK8); // R21
			`TCM_CS_DIV64:   s_nxt.tick = ((s_r.presc & `TCM_MASK64) == `TCM_MASK64); // R21
			`TCM_CS_DIV256:  s_nxt.tick = ((s_r.presc & `TCM_MASK256) == `TCM_MASK256); // R21
			`TCM_CS_DIV1024: s_nxt.tick = ((s_r.presc & `TCM_MASK1024) == `TCM_MASK1024); // R21
			default:         s_nxt.tick = 1'b0;
		endcase

		// counter: software write wins over clear and count
		if (wr_count)
		begin
			s_nxt.count = i_pwdata[7:0]; // R14 R28
			s_nxt.block = 1'b1; // R24
		end
		else if (s_r.tick)
		begin
			s_nxt.block = 1'b0;
			if (ctc_mode && hit[0])
				s_nxt.count = `TCM_BOTTOM; // R16 R20
			else
				s_nxt.count = s_r.count + 8'h01; // R11 R27
		end

		// overflow on the tick that rolls max to bottom; clears on service or write one
		if (s_r.tick && !wr_count && (s_r.count == `TCM_MAX))
			s_nxt.ovf = 1'b1; // R12 R13 R22
		else if (i_svc_ovf || (wr_flags && i_pwdata[`TCM_FLG_OVF]))
			s_nxt.ovf = 1'b0; // R13 R26

		// compare flags: a real match sets, a force never does; set beats clear
		if (hit[0])
			s_nxt.cflag[0] = 1'b1; // R17 R23 R25
		else if (svc_cmp[0] || (wr_flags && i_pwdata[`TCM_FLG_CMPA]))
			s_nxt.cflag[0] = 1'b0; // R26
		if (hit[1])
			s_nxt.cflag[1] = 1'b1; // R23 R25
		else if (svc_cmp[1] || (wr_flags && i_pwdata[`TCM_FLG_CMPB]))
			s_nxt.cflag[1] = 1'b0; // R26

		s_nxt.oc = oc_nxt;

		// pin override depends on the action field only, never on the mode
		s_nxt.pins.level[0] = (s_nxt.act[0] != `TCM_ACT_NONE) ? s_nxt.oc[0] : s_nxt.port_out[0]; // R2 R4
		s_nxt.pins.level[1] = (s_nxt.act[1] != `TCM_ACT_NONE) ? s_nxt.oc[1] : s_nxt.port_out[1]; // R2 R4
		s_nxt.pins.oe       = s_nxt.dir; // R3
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			s_r        <= '0; // R1
			s_r.apb_st <= TCM_ST_IDLE;
		end
		else
			s_r <= s_nxt;
	end

	assign o_prdata   = s_r.prdata;
	assign o_pready   = s_r.pready;
	assign o_pslverr  = s_r.pslverr;
	assign o_pins     = s_r.pins;
	assign o_ovf_flag = s_r.ovf;
	assign o_cmp_flag = s_r.cflag;

	AST_OC_RESET: assert property ( // R1
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(i_rst_n) |-> (s_r.oc == 2'b00) && (o_pins.level == 2'b00))
		else $error("compare output state not zero after reset");

	AST_PIN_OVERRIDE: assert property ( // R2
		@(posedge i_clk) disable iff (!i_rst_n)
		(s_r.act[0] != `TCM_ACT_NONE) |-> (o_pins.level[0] == s_r.oc[0]))
		else $error("pin a not driven from compare output state");

	AST_PIN_PORT: assert property ( // R4
		@(posedge i_clk) disable iff (!i_rst_n)
		(s_r.act[1] == `TCM_ACT_NONE) |-> (o_pins.level[1] == s_r.port_out[1]))
		else $error("pin b not driven from port value without override");

	AST_PIN_DIR: assert property ( // R3
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_port |=> (o_pins.oe == $past(i_pwdata[`TCM_PORT_DIR])))
		else $error("pin enable does not follow direction bits");

	AST_ACT_NONE_HOLD: assert property ( // R6
		@(posedge i_clk) disable iff (!i_rst_n)
		(s_r.act[0] == `TCM_ACT_NONE) && hit[0] |=> $stable(s_r.oc[0]))
		else $error("state changed at match with no action");

	AST_TOGGLE: assert property ( // R19
		@(posedge i_clk) disable iff (!i_rst_n)
		hit[0] && (s_r.act[0] == `TCM_ACT_TOGGLE) |=> (s_r.oc[0] != $past(s_r.oc[0])))
		else $error("toggle action did not toggle");

	AST_FORCE_SET: assert property ( // R8
		@(posedge i_clk) disable iff (!i_rst_n)
		force_hit[1] && (s_r.act[1] == `TCM_ACT_SET) |=> s_r.oc[1])
		else $error("forced set did not set state");

	AST_NORMAL_WRAP: assert property ( // R11
		@(posedge i_clk) disable iff (!i_rst_n)
		(s_r.wgm == `TCM_WGM_NORMAL) && s_r.tick && !wr_count && (s_r.count == `TCM_MAX)
		|=> (s_r.count == `TCM_BOTTOM) && s_r.ovf)
		else $error("normal mode wrap or overflow wrong");

	AST_CTC_CLEAR: assert property ( // R16
		@(posedge i_clk) disable iff (!i_rst_n)
		ctc_mode && hit[0] && !wr_count |=> (s_r.count == `TCM_BOTTOM) && s_r.cflag[0])
		else $error("clear-on-match did not clear or flag");

	AST_BLOCK: assert property ( // R24
		@(posedge i_clk) disable iff (!i_rst_n)
		s_r.tick && s_r.block && !svc_cmp[0] && !wr_flags |=> $stable(s_r.cflag[0]))
		else $error("match not blocked after counter write");

	AST_FORCE_NO_FLAG: assert property ( // R25
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_force && !s_r.tick && !svc_cmp[0] |=> $stable(s_r.cflag[0]) && $stable(s_r.count))
		else $error("force changed flag or counter");

	AST_FLAG_W1C: assert property ( // R26
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_flags && i_pwdata[`TCM_FLG_CMPB] && !hit[1] |=> !s_r.cflag[1])
		else $error("write one did not clear flag");

	AST_WR_PRIORITY: assert property ( // R28
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_count |=> (s_r.count == $past(i_pwdata[7:0])) && s_r.block)
		else $error("counter write lost");

	AST_DIV1_TICK: assert property ( // R21
		@(posedge i_clk) disable iff (!i_rst_n)
		(s_r.cs == `TCM_CS_DIV1) ##1 (s_r.cs == `TCM_CS_DIV1) |-> s_r.tick)
		else $error("undivided tick missing");

	AST_NO_TICK_HOLD: assert property ( // R27
		@(posedge i_clk) disable iff (!i_rst_n)
		!s_r.tick && !wr_count |=> $stable(s_r.count))
		else $error("counter moved without tick");

	AST_OVF_CTC: assert property ( // R22
		@(posedge i_clk) disable iff (!i_rst_n)
		ctc_mode && s_r.tick && !wr_count && (s_r.count == `TCM_MAX) |=> s_r.ovf)
		else $error("overflow not set on rollover in clear-on-match mode");

	AST_FLAG_B_SET: assert property ( // R23
		@(posedge i_clk) disable iff (!i_rst_n)
		hit[1] |=> s_r.cflag[1])
		else $error("compare flag b not set after match");

	AST_OVF_HOLD: assert property ( // R13
		@(posedge i_clk) disable iff (!i_rst_n)
		s_r.ovf && !i_svc_ovf && !(wr_flags && i_pwdata[`TCM_FLG_OVF]) |=> s_r.ovf)
		else $error("overflow flag cleared by hardware");

	AST_OVF_SVC_CLEAR: assert property ( // R13
		@(posedge i_clk) disable iff (!i_rst_n)
		i_svc_ovf && !(s_r.tick && (s_r.count == `TCM_MAX)) |=> !s_r.ovf)
		else $error("service did not clear overflow flag");

	AST_FORCE_SET_A: assert property ( // R8
		@(posedge i_clk) disable iff (!i_rst_n)
		force_hit[0] && (s_r.act[0] == `TCM_ACT_SET) |=> s_r.oc[0])
		else $error("forced set did not set state a");

	AST_PWM_NO_FORCE: assert property ( // R8
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_force && pwm_mode && !hit[0] |=> $stable(s_r.oc[0]))
		else $error("force acted in a pwm mode");

	AST_CMP_WR: assert property ( // R18
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_cmpa |=> (s_r.cmp[0] == $past(i_pwdata[7:0])))
		else $error("compare value a not taken at once");

	AST_PIN_B_OVERRIDE: assert property ( // R2
		@(posedge i_clk) disable iff (!i_rst_n)
		(s_r.act[1] != `TCM_ACT_NONE) |-> (o_pins.level[1] == s_r.oc[1]))
		else $error("pin b not driven from compare output state");

	AST_MODE_WR: assert property ( // R9
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_ctrl |=> (s_r.wgm == $past(i_pwdata[`TCM_CTRL_WGM])))
		else $error("mode select not taken");

	AST_NORMAL_COUNT: assert property ( // R11
		@(posedge i_clk) disable iff (!i_rst_n)
		(s_r.wgm == `TCM_WGM_NORMAL) && s_r.tick && !wr_count && (s_r.count != `TCM_MAX)
		|=> (s_r.count == $past(s_r.count) + 8'h01))
		else $error("normal mode did not increment");

	AST_FLAG_A_W1C: assert property ( // R26
		@(posedge i_clk) disable iff (!i_rst_n)
		wr_flags && i_pwdata[`TCM_FLG_CMPA] && !hit[0] |=> !s_r.cflag[0])
		else $error("write one did not clear flag a");

endmodule
`default_nettype wire

/* File: verification/tcm_pin_load.sv */
// pin loads and interrupt service model on the far side of the timer
`timescale 1ns/100ps
`default_nettype none

module tcm_pin_load
	import tcm_pkg::*;
(
	// clock
	input  wire logic         i_clk,
	// from the timer and the bench
	input  wire tcm_pins_type i_pins,
	input  wire logic [2:0]   i_svc_req,
	// resolved pins and service pulses
	output var  logic [1:0]   o_wire,
	output var  logic [2:0]   o_svc
);
	// a pin not driven floats to its pull-up
	always_comb o_wire = (i_pins.level & i_pins.oe) | ~i_pins.oe;
	// interrupt service request shows as an acknowledge one cycle later, lasting as long as the request
	always_ff @(posedge i_clk) o_svc <= i_svc_req;
endmodule

`default_nettype wire

/* File: verification/test_tcm_timer.sv */
// self-checking bench for the compare-output timer
`timescale 1ns/100ps
`default_nettype none
`include "tcm_map.svh"

module test_tcm_timer
	import tcm_pkg::*;
;
	logic         i_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, ovf, err, lv;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [1:0]   cflag, wire_lvl;
	logic [2:0]   svc, svc_req;
	tcm_pins_type pins;
	int           mismatches, total_checks, cyc, n;
	int           divs [5] = '{1, 8, 64, 256, 1024};

	tcm_timer u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_svc_ovf(svc[0]), .i_svc_cmp_a(svc[1]),
		.i_svc_cmp_b(svc[2]), .o_pins(pins), .o_ovf_flag(ovf), .o_cmp_flag(cflag));
	tcm_pin_load u_load (.i_clk(i_clk), .i_pins(pins), .i_svc_req(svc_req),
		.o_wire(wire_lvl), .o_svc(svc));

	initial
	begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask

	function automatic logic [31:0] ctrl(input logic [2:0] m, input logic [2:0] cs,
		input logic [1:0] act);
		return {22'h0, 2'h0, act, cs, m};
	endfunction

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// cut a hang short
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			mismatches++;
			final_report;
		end
	end

	initial
	begin
		i_rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		svc_req = 3'h0;
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		tick(1);
		chk(32'(pins), 32'h0);
		chk(32'({ovf, cflag}), 32'h0);
		$display("test reset done");

		// preset state a while the pin is still an input
		wr(`TCM_OFF_CTRL, 32'h0000_03C0);
		wr(`TCM_OFF_FORCE, 32'h3);
		rdchk(`TCM_OFF_PORT, 32'h30);
		chk(32'(pins.oe), 32'h0);
		rdchk(`TCM_OFF_FLAGS, 32'h0);
		rdchk(`TCM_OFF_COUNT, 32'h0);
		wr(`TCM_OFF_PORT, 32'h4);
		tick(2);
		chk(32'(wire_lvl[0]), 32'h1);
		wr(`TCM_OFF_CTRL, ctrl(`TCM_WGM_NORMAL, 3'h0, `TCM_ACT_NONE));
		tick(2);
		chk(32'(wire_lvl[0]), 32'h0);
		wr(`TCM_OFF_CTRL, ctrl(`TCM_WGM_CTC, 3'h0, `TCM_ACT_SET));
		tick(2);
		chk(32'(wire_lvl[0]), 32'h1);
		apb(1'b0, 8'h1C, 32'h0);
		chk(rd, 32'h0);
		chk(32'(err), 32'h1);
		$display("test override done");

		// toggle waveform in clear-on-match mode over every prescale ratio
		wr(`TCM_OFF_COUNT, 32'h0);
		wr(`TCM_OFF_CMPA, 32'h0);
		for (int k = 0; k < 5; k++)
		begin
			wr(`TCM_OFF_CTRL, ctrl(`TCM_WGM_CTC, 3'(k + 1), `TCM_ACT_TOGGLE));
			for (int j = 0; j < 2; j++)
			begin
				lv = pins.level[0];
				n = 0;
				do begin tick(1); n++; end while (pins.level[0] === lv && n < 3000);
			end
			chk(32'(n), 32'(divs[k]));
		end
		chk(32'(cflag[0]), 32'h1);
		rdchk(`TCM_OFF_COUNT, 32'h0);
		for (int k = 0; k < 2; k++)
		begin
			wr(`TCM_OFF_CTRL, ctrl(`TCM_WGM_CTC, `TCM_CS_DIV1, k ? `TCM_ACT_CLEAR : `TCM_ACT_SET));
			tick(3);
			chk(32'(pins.level[0]), 32'(k == 0));
			tick(1);
			chk(32'(pins.level[0]), 32'(k == 0));
		end
		$display("test toggle done");

		// top written below the count is missed until after the wrap
		wr(`TCM_OFF_CTRL, ctrl(`TCM_WGM_CTC, 3'h0, `TCM_ACT_NONE));
		wr(`TCM_OFF_COUNT, 32'h80);
		wr(`TCM_OFF_CMPA, 32'h10);
		wr(`TCM_OFF_FLAGS, 32'h7);
		wr(`TCM_OFF_CTRL, ctrl(`TCM_WGM_CTC, `TCM_CS_DIV1, `TCM_ACT_NONE));
		tick(20);
		chk(32'(cflag[0]), 32'h0);
		tick(300);
		chk(32'(cflag[0]), 32'h1);
		chk(32'(ovf), 32'h1);
		$display("test missed top done");

		// overflow in normal mode, cleared only by software or service
		wr(`TCM_OFF_CTRL, ctrl(`TCM_WGM_NORMAL, 3'h0, `TCM_ACT_NONE));
		wr(`TCM_OFF_COUNT, 32'hFD);
		wr(`TCM_OFF_FLAGS, 32'h7);
		wr(`TCM_OFF_CTRL, ctrl(`TCM_WGM_NORMAL, `TCM_CS_DIV1, `TCM_ACT_NONE));
		tick(10);
		chk(32'(ovf), 32'h1);
		wr(`TCM_OFF_FLAGS, 32'h1);
		apb(1'b0, `TCM_OFF_FLAGS, 32'h0);
		chk(32'(rd[0]), 32'h0);
		tick(300);
		chk(32'(ovf), 32'h1);
		wr(`TCM_OFF_CTRL, ctrl(`TCM_WGM_NORMAL, 3'h0, `TCM_ACT_NONE));
		svc_req <= 3'h1;
		@(posedge i_clk);
		svc_req <= 3'h0;
		tick(3);
		chk(32'(ovf), 32'h0);
		$display("test overflow done");

		// a counter write hides the match at the next tick
		wr(`TCM_OFF_CMPA, 32'h5);
		wr(`TCM_OFF_COUNT, 32'h5);
		wr(`TCM_OFF_FLAGS, 32'h7);
		wr(`TCM_OFF_CTRL, ctrl(`TCM_WGM_NORMAL, `TCM_CS_DIV1, `TCM_ACT_NONE));
		tick(6);
		chk(32'(cflag[0]), 32'h0);
		tick(300);
		chk(32'(cflag[0]), 32'h1);
		$display("test match block done");
		final_report;
	end
endmodule

`default_nettype wire
